// ### design/pmr_pkg.sv
// Constants and types for the coding sublayer management register bank
package pmr_pkg;

   // Register offsets inside the sublayer device
   localparam logic [15:0] REG_CTRL1    = 16'h0000;
   localparam logic [15:0] REG_STAT1    = 16'h0001;
   localparam logic [15:0] REG_ID_LO    = 16'h0002;
   localparam logic [15:0] REG_ID_HI    = 16'h0003;
   localparam logic [15:0] REG_SPEED    = 16'h0004;
   localparam logic [15:0] REG_PKG_LO   = 16'h0005;
   localparam logic [15:0] REG_PKG_HI   = 16'h0006;
   localparam logic [15:0] REG_CTRL2    = 16'h0007;
   localparam logic [15:0] REG_STAT2    = 16'h0008;
   localparam logic [15:0] REG_PKGID_LO = 16'h000e;
   localparam logic [15:0] REG_PKGID_HI = 16'h000f;
   localparam logic [15:0] REG_LPI_CAP  = 16'h0014;
   localparam logic [15:0] REG_STACK    = 16'ha939;

   // Control one fields
   localparam int CTL_RESET_BIT   = 15;
   localparam int CTL_LPBK_BIT    = 14;
   localparam int CTL_LOWPWR_BIT  = 11;
   localparam int CTL_CLKSTOP_BIT = 10;
   localparam int CTL_SPD_LSB     = 2;
   localparam logic [15:0] CTL_RW_MASK  = 16'h5fbf;
   localparam logic [15:0] CTL_RO_ONES  = 16'h2040;
   localparam logic [15:0] CTL_RESET    = 16'h0000;

   // Status one fields
   localparam int ST1_TXLIVE_BIT = 9;
   localparam int ST1_RXLIVE_BIT = 8;

   // Constant capability words
   localparam logic [15:0] SPEED_ABILITY = 16'h00c1;
   localparam logic [15:0] PKG_DEV_LO    = 16'h009b;
   localparam logic [15:0] PKG_DEV_HI    = 16'hc000;
   localparam logic [15:0] STAT2_CONST   = 16'hb008;
   localparam logic [15:0] PKG_ID_LO     = 16'h0000;
   localparam logic [15:0] PKG_ID_HI     = 16'h0000;
   localparam logic [15:0] LPI_CAP       = 16'h0008;
   localparam logic [1:0]  PRESENT_CODE  = 2'h2;

   // Sublayer type codes and active speed encodings
   localparam logic [3:0] TYPE_10G   = 4'h3;
   localparam logic [3:0] TYPE_5G    = 4'hb;
   localparam logic [3:0] TYPE_2P5G  = 4'ha;
   localparam logic [3:0] TYPE_RESET = 4'h3;
   localparam logic [1:0] SPD_10G    = 2'h0;
   localparam logic [1:0] SPD_5G     = 2'h1;
   localparam logic [1:0] SPD_2P5G   = 2'h2;

   // Stacking header enables
   localparam int STK_TX_EN_BIT  = 0;
   localparam int STK_TS_BIT     = 1;
   localparam int STK_LEN32_BIT  = 2;
   localparam int STK_RX_EN_BIT  = 7;
   localparam logic [15:0] STK_RW_MASK = 16'h0087;
   localparam logic [15:0] STK_RESET   = 16'h0000;

   // Management frame layout
   localparam logic [1:0] OP_ADDR     = 2'h0;
   localparam logic [1:0] OP_WRITE    = 2'h1;
   localparam logic [1:0] OP_READ_INC = 2'h2;
   localparam logic [5:0] PRE_LEN     = 6'h20;
   localparam logic [4:0] HDR_LAST    = 5'h0c;
   localparam logic [4:0] TA_LAST     = 5'h01;
   localparam logic [4:0] DATA_LAST   = 5'h0f;
   localparam logic [4:0] DEVAD_PCS   = 5'h03;

   // Latched status cells
   localparam int LAT_TX_LPI = 0;
   localparam int LAT_RX_LPI = 1;
   localparam int LAT_RXF    = 2;
   localparam int LAT_LINK   = 3;
   localparam int LAT_NUM    = 4;
   localparam logic [3:0] LAT_HIGH_MASK = 4'h7;

   typedef enum logic [1:0] {PH_PRE, PH_HDR, PH_TA, PH_DATA} pmr_phase_e;

endpackage

// ### design/pmr_latch_bit.sv
// One latched status bit, latching high or low, reloaded from live on read
`timescale 1ns/10ps
module pmr_latch_bit #(
   parameter bit LATCH_HIGH = 1'b1
) (
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   input  wire logic live_i,
   input  wire logic clear_i,
   output logic      latched_o
);

   logic latched_q;
   logic latched_d;

   // On read the bit follows live, so an event in that cycle still sticks
   always_comb begin
      if (clear_i) begin
         latched_d = live_i;
      end else if (LATCH_HIGH) begin
         latched_d = latched_q | live_i;
      end else begin
         latched_d = latched_q & live_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         latched_q <= 1'b0;
      end else begin
         latched_q <= latched_d;
      end
   end

   assign latched_o = latched_q;

endmodule // pmr_latch_bit

// ### design/pmr_mgmt_regs.sv
// Coding sublayer management registers behind a Clause 45 management slave
`timescale 1ns/10ps
// Summary of operation
// - Control bit 14 loops transmit data back to receive; resets to 0.
// - Control bit 11 requests low-power mode; resets to 0.
// - Control bit 10 says the clock may stop during low-power idle.
// - Control bits 13 and 6 read as ones, meaning 10 Gb/s.
// - Type field reports 1011, 1010 or 0011 for active speed; resets 0x3.
// - Status bit 11 latches high on transmit low-power idle until read.
// - Status bit 10 latches high on receive low-power idle until read.
// - Status bits 9 and 8 show live transmit and receive idle.
// - Status bit 7 reads 1 while any fault is present.
// - Status bit 2 latches low on link loss until read.
// - Status bit 1 reads 1, low-power mode supported.
// - Two identifier words together form a 32-bit identifier.
// - Speed ability reads bits 7, 6, 0 set and bit 1 clear.
// - First package word reads bits 7,4,3,1,0 set, 6,5,2 clear.
// - Second package word reads bits 15,14 set and 13 clear.
// - Present field in second status reads 10.
// - Second status bit 10 latches receive fault; bit 11 shows transmit fault.
// - Second status reads bits 13,12,3 set and bits 2 to 0 clear.
// - Idle capability reads bit 3 set and bits 6 to 4 clear.
// - Stacking header enables bits 0,1,2,7 are writable, reset 0.
module pmr_mgmt_regs
   import pmr_pkg::*;
#(
   parameter logic [4:0]  PORT_ADDR  = 5'h00,
   // Identifier values are arbitrary
   parameter logic [15:0] IDENT_LOW  = 16'h1a2b,
   parameter logic [15:0] IDENT_HIGH = 16'h3c4d
) (
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   input  wire logic       mdc_i,
   input  wire logic       mdio_i,
   output logic            mdio_o,
   output logic            mdio_oe_o,
   input  wire logic       tx_lpi_i,
   input  wire logic       rx_lpi_i,
   input  wire logic       tx_fault_i,
   input  wire logic       rx_fault_i,
   input  wire logic       rx_link_i,
   input  wire logic [1:0] active_speed_i,
   output logic            sublayer_reset_o,
   output logic            sublayer_loopback_enable_o,
   output logic            low_power_request_o,
   output logic            clock_stoppable_o,
   output logic [3:0]      extended_speed_field_o,
   output logic            tx_stacking_header_enable_o,
   output logic            rx_stacking_header_enable_o,
   output logic            tx_timestamp_code_enable_o,
   output logic            tx_long_message_select_o
);

   logic               mdc_q;
   logic               mdc_rise;
   logic               mdc_fall;
   pmr_phase_e         phase_q;
   logic [5:0]         pre_cnt_q;
   logic [4:0]         cnt_q;
   logic [12:0]        hdr_q;
   logic [12:0]        hdr_next;
   logic [1:0]         op_q;
   logic               mine_q;
   logic               hdr_done;
   logic               hdr_mine;
   logic               data_last;
   logic               rd_take;
   logic               wr_take;
   logic [15:0]        addr_q;
   logic [15:0]        wr_sh_q;
   logic [15:0]        wr_word;
   logic [15:0]        rd_sh_q;
   logic [15:0]        rd_word;
   logic               mdio_q;
   logic               mdio_oe_q;
   logic [15:0]        ctl_q;
   logic               reset_q;
   logic [15:0]        stk_q;
   logic [3:0]         type_q;
   logic               tx_live_q;
   logic               rx_live_q;
   logic               fault_q;
   logic               tx_fault_q;
   logic               clr_st1;
   logic               clr_st2;
   logic [LAT_NUM-1:0] lat_live;
   logic [LAT_NUM-1:0] lat_clr;
   logic [LAT_NUM-1:0] lat_q;
   logic               wr_ctl1;
   logic               wr_stack;

   // Both pins are synchronous, so one stored sample of the clock suffices
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mdc_q <= 1'b0;
      end else begin
         mdc_q <= mdc_i;
      end
   end

   assign mdc_rise  = mdc_i & ~mdc_q;
   assign mdc_fall  = ~mdc_i & mdc_q;
   assign hdr_next  = {hdr_q[11:0], mdio_i};
   assign hdr_done  = mdc_rise && (phase_q == PH_HDR) && (cnt_q == HDR_LAST);
   assign hdr_mine  = hdr_next[12] && (hdr_next[9:5] == PORT_ADDR)
                      && (hdr_next[4:0] == DEVAD_PCS);
   assign data_last = mdc_rise && (phase_q == PH_DATA) && (cnt_q == DATA_LAST);
   // Both read opcodes have the upper bit set
   assign rd_take   = hdr_done && hdr_mine && hdr_next[11];
   assign wr_word   = {wr_sh_q[14:0], mdio_i};
   assign wr_take   = data_last && mine_q && (op_q == OP_WRITE);
   assign wr_ctl1   = wr_take && (addr_q == REG_CTRL1);
   assign wr_stack  = wr_take && (addr_q == REG_STACK);
   assign clr_st1   = rd_take && (addr_q == REG_STAT1);
   assign clr_st2   = rd_take && (addr_q == REG_STAT2);

   // Frame tracker; a full preamble is needed before every frame
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         phase_q   <= PH_PRE;
         pre_cnt_q <= 6'h00;
         cnt_q     <= 5'h00;
         hdr_q     <= 13'h0000;
         op_q      <= OP_ADDR;
         mine_q    <= 1'b0;
      end else if (mdc_rise) begin
         unique case (phase_q)
            PH_PRE: begin
               if (mdio_i) begin
                  if (pre_cnt_q != PRE_LEN) begin
                     pre_cnt_q <= pre_cnt_q + 6'h01;
                  end
               end else begin
                  if (pre_cnt_q == PRE_LEN) begin
                     phase_q <= PH_HDR;
                     cnt_q   <= 5'h00;
                  end
                  pre_cnt_q <= 6'h00;
               end
            end
            PH_HDR: begin
               hdr_q <= hdr_next;
               if (cnt_q == HDR_LAST) begin
                  phase_q <= PH_TA;
                  cnt_q   <= 5'h00;
                  op_q    <= hdr_next[11:10];
                  mine_q  <= hdr_mine;
               end else begin
                  cnt_q <= cnt_q + 5'h01;
               end
            end
            PH_TA: begin
               if (cnt_q == TA_LAST) begin
                  phase_q <= PH_DATA;
                  cnt_q   <= 5'h00;
               end else begin
                  cnt_q <= cnt_q + 5'h01;
               end
            end
            PH_DATA: begin
               if (cnt_q == DATA_LAST) begin
                  phase_q <= PH_PRE;
                  cnt_q   <= 5'h00;
               end else begin
                  cnt_q <= cnt_q + 5'h01;
               end
            end
         endcase
      end
   end

   // Incoming data word; the last bit joins directly from the pin
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         wr_sh_q <= 16'h0000;
      end else if (mdc_rise && (phase_q == PH_DATA)) begin
         wr_sh_q <= wr_word;
      end
   end

   // Address register with post-read increment
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         addr_q <= 16'h0000;
      end else if (data_last && mine_q && (op_q == OP_ADDR)) begin
         addr_q <= wr_word;
      end else if (data_last && mine_q && (op_q == OP_READ_INC)) begin
         addr_q <= addr_q + 16'h0001;
      end
   end

   // Read drive: released on the first turnaround bit, zero on the second
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rd_sh_q   <= 16'h0000;
         mdio_q    <= 1'b0;
         mdio_oe_q <= 1'b0;
      end else if (rd_take) begin
         rd_sh_q <= rd_word;
      end else if (mdc_fall) begin
         if (mine_q && op_q[1] && (phase_q == PH_TA) && (cnt_q == TA_LAST)) begin
            mdio_q    <= 1'b0;
            mdio_oe_q <= 1'b1;
         end else if (mine_q && op_q[1] && (phase_q == PH_DATA)) begin
            mdio_q    <= rd_sh_q[15];
            mdio_oe_q <= 1'b1;
            rd_sh_q   <= {rd_sh_q[14:0], 1'b0};
         end else begin
            mdio_q    <= 1'b0;
            mdio_oe_q <= 1'b0;
         end
      end
   end

   assign mdio_o    = mdio_q;
   assign mdio_oe_o = mdio_oe_q;

   // Control one; reserved writable bits are kept so a read-modify-write holds them
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ctl_q   <= CTL_RESET;
         reset_q <= 1'b0;
      end else begin
         reset_q <= wr_ctl1 && wr_word[CTL_RESET_BIT];
         if (wr_ctl1) begin
            ctl_q <= wr_word & CTL_RW_MASK;
         end
      end
   end

   assign sublayer_reset_o           = reset_q;
   assign sublayer_loopback_enable_o = ctl_q[CTL_LPBK_BIT];
   assign low_power_request_o        = ctl_q[CTL_LOWPWR_BIT];
   assign clock_stoppable_o          = ctl_q[CTL_CLKSTOP_BIT];
   assign extended_speed_field_o     = ctl_q[CTL_SPD_LSB +: 4];

   // Stacking header enables
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         stk_q <= STK_RESET;
      end else if (wr_stack) begin
         stk_q <= wr_word & STK_RW_MASK;
      end
   end

   assign tx_stacking_header_enable_o = stk_q[STK_TX_EN_BIT];
   assign rx_stacking_header_enable_o = stk_q[STK_RX_EN_BIT];
   assign tx_timestamp_code_enable_o  = stk_q[STK_TS_BIT];
   assign tx_long_message_select_o    = stk_q[STK_LEN32_BIT];

   // Live status and active sublayer type
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         tx_live_q  <= 1'b0;
         rx_live_q  <= 1'b0;
         fault_q    <= 1'b0;
         tx_fault_q <= 1'b0;
         type_q     <= TYPE_RESET;
      end else begin
         tx_live_q  <= tx_lpi_i;
         rx_live_q  <= rx_lpi_i;
         fault_q    <= tx_fault_i | rx_fault_i;
         tx_fault_q <= tx_fault_i;
         unique case (active_speed_i)
            SPD_5G:   type_q <= TYPE_5G;
            SPD_2P5G: type_q <= TYPE_2P5G;
            SPD_10G:  type_q <= TYPE_10G;
            default:  type_q <= type_q;
         endcase
      end
   end

   // Latched status cells, cleared by the read that returns them
   assign lat_live = {rx_link_i, rx_fault_i, rx_lpi_i, tx_lpi_i};
   assign lat_clr  = {clr_st1, clr_st2, clr_st1, clr_st1};

   generate
      for (genvar i = 0; i < LAT_NUM; i++) begin : g_lat
         pmr_latch_bit #(
            .LATCH_HIGH (LAT_HIGH_MASK[i])
         ) u_lat (
            .core_clk_i (core_clk_i),
            .rst_i      (rst_i),
            .live_i     (lat_live[i]),
            .clear_i    (lat_clr[i]),
            .latched_o  (lat_q[i])
         );
      end
   endgenerate

   // Read multiplexer; unmapped offsets read zero
   always_comb begin
      unique case (addr_q)
         REG_CTRL1:    rd_word = ctl_q | CTL_RO_ONES;
         REG_STAT1:    rd_word = {4'h0, lat_q[LAT_TX_LPI], lat_q[LAT_RX_LPI],
                                  tx_live_q, rx_live_q, fault_q, 4'h0,
                                  lat_q[LAT_LINK], 1'b1, 1'b0};
         REG_ID_LO:    rd_word = IDENT_LOW;
         REG_ID_HI:    rd_word = IDENT_HIGH;
         REG_SPEED:    rd_word = SPEED_ABILITY;
         REG_PKG_LO:   rd_word = PKG_DEV_LO;
         REG_PKG_HI:   rd_word = PKG_DEV_HI;
         REG_CTRL2:    rd_word = {12'h000, type_q};
         REG_STAT2:    rd_word = STAT2_CONST | {4'h0, tx_fault_q,
                                  lat_q[LAT_RXF], 10'h000};
         REG_PKGID_LO: rd_word = PKG_ID_LO;
         REG_PKGID_HI: rd_word = PKG_ID_HI;
         REG_LPI_CAP:  rd_word = LPI_CAP;
         REG_STACK:    rd_word = stk_q;
         default:      rd_word = 16'h0000;
      endcase
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence st1_read_s;
      rd_take && (addr_q == REG_STAT1);
   endsequence

   sequence rx_idle_gone_s;
      st1_read_s ##0 !rx_lpi_i;
   endsequence

   loopback_set_a: assert property (
      (wr_ctl1 && wr_word[CTL_LPBK_BIT]) |=> sublayer_loopback_enable_o)
      else $error("loopback not enabled after control write");
   low_power_clear_a: assert property (
      (wr_ctl1 && !wr_word[CTL_LOWPWR_BIT]) |=> !low_power_request_o)
      else $error("low power still requested after clearing write");
   clock_stop_a: assert property (
      wr_ctl1 |=> (clock_stoppable_o == $past(wr_word[CTL_CLKSTOP_BIT])))
      else $error("clock stoppable bit mismatch");
   speed_ones_a: assert property (
      (rd_take && (addr_q == REG_CTRL1)) |=> (rd_sh_q[13] && rd_sh_q[6]))
      else $error("speed selection bits not both one");
   type_five_a: assert property (
      (active_speed_i == SPD_5G) |=> (type_q == TYPE_5G))
      else $error("type field not five gig code");
   tx_idle_latch_a: assert property (
      tx_lpi_i |=> lat_q[LAT_TX_LPI] [*1])
      else $error("transmit idle not latched");
   rx_idle_return_a: assert property (
      rx_idle_gone_s |=> !lat_q[LAT_RX_LPI])
      else $error("receive idle latch not returned to live after read");
   live_idle_a: assert property (
      st1_read_s |-> (rd_word[ST1_TXLIVE_BIT] == $past(tx_lpi_i))
                     && (rd_word[ST1_RXLIVE_BIT] == $past(rx_lpi_i)))
      else $error("live idle bits do not follow inputs");
   link_low_latch_a: assert property (
      !rx_link_i ##1 !clr_st1 |-> !lat_q[LAT_LINK])
      else $error("link loss not latched low");
   ident_high_a: assert property (
      (rd_take && (addr_q == REG_ID_HI)) |=> (rd_sh_q == IDENT_HIGH))
      else $error("identifier high word wrong");
   present_field_a: assert property (
      (rd_take && (addr_q == REG_STAT2)) |=> (rd_sh_q[15:14] == PRESENT_CODE))
      else $error("device present field wrong");
   stack_enable_a: assert property (
      (wr_stack && wr_word[STK_RX_EN_BIT]) |=> rx_stacking_header_enable_o [*2])
      else $error("receive stacking enable not held");

endmodule // pmr_mgmt_regs

// ### verif/pmr_sme_model.sv
// Station management model that issues management frames to the register bank
`timescale 1ns/10ps
module pmr_sme_model
   import pmr_pkg::*;
#(
   parameter logic [4:0] PORT = 5'h00
) (
   input  wire logic core_clk_i,
   input  wire logic mdio_i,
   input  wire logic mdio_oe_i,
   output logic      mdc_o,
   output logic      line_o
);
   logic drv = 1'b0;
   logic bit_v = 1'b1;

   // Pull-up holds the line high whenever nobody drives it
   assign line_o = mdio_oe_i ? mdio_i : (drv ? bit_v : 1'b1);
   initial mdc_o = 1'b0;

   // Four core cycles a half period keeps the device's edge sampler safe
   task automatic one_bit(input logic d, input logic b, output logic s);
      mdc_o = 1'b0;
      drv = d;
      bit_v = b;
      repeat (4) @(negedge core_clk_i);
      s = line_o;
      mdc_o = 1'b1;
      repeat (4) @(negedge core_clk_i);
   endtask

   task automatic frame(input logic [1:0] op, input logic [4:0] prt, input logic [4:0] dev,
                        input logic [15:0] wd, output logic [15:0] rd_v);
      logic [31:0] f;
      logic s;
      f = {2'b01, op, prt, dev, 2'b10, wd};
      rd_v = 16'h0000;
      @(negedge core_clk_i);
      for (int i = 0; i < 32; i++) one_bit(1'b1, 1'b1, s);
      // Read frames hand turnaround and data over to the device
      for (int i = 31; i >= 0; i--) begin
         one_bit(!(op[1] && i < 18), f[i], s);
         if (i < 16) rd_v[i] = s;
      end
      mdc_o = 1'b0;
      drv = 1'b0;
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      logic [15:0] x;
      frame(OP_ADDR, PORT, DEVAD_PCS, a, x);
      frame(OP_WRITE, PORT, DEVAD_PCS, d, x);
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      logic [15:0] x;
      frame(OP_ADDR, PORT, DEVAD_PCS, a, x);
      frame(2'h3, PORT, DEVAD_PCS, 16'h0000, d);
   endtask

   // Reserved writable bits go back exactly as read
   task automatic rmw(input logic [15:0] a, input logic [15:0] s, input logic [15:0] c);
      logic [15:0] v;
      rd(a, v);
      wr(a, (v | s) & ~c);
   endtask
endmodule // pmr_sme_model

// ### verif/tb.sv
// Self-checking bench for the sublayer management register bank
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb;
   import pmr_pkg::*;
   localparam logic [4:0]  PORT  = 5'h05;
   // Identifier values are arbitrary
   localparam logic [15:0] ID_LO = 16'h0123;
   localparam logic [15:0] ID_HI = 16'h4567;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic mdc, line, mdio_o, mdio_oe;
   logic tx_lpi = 1'b0, rx_lpi = 1'b0, tx_fault = 1'b0, rx_fault = 1'b0, rx_link = 1'b1;
   logic [1:0]  spd = 2'h0;
   logic rst_pulse, lpbk, low_power_request, clk_stop, tx_hdr, rx_hdr, ts_en, len32;
   logic [3:0]  espd;
   logic [15:0] v, w;
   int err_total = 0;
   int n_checks = 0;
   int cycles = 0;
   int pulses = 0;
   int oe_cycles = 0;

   pmr_sme_model #(.PORT(PORT)) sme (.core_clk_i(core_clk_i), .mdio_i(mdio_o),
      .mdio_oe_i(mdio_oe), .mdc_o(mdc), .line_o(line));

   pmr_mgmt_regs #(.PORT_ADDR(PORT), .IDENT_LOW(ID_LO), .IDENT_HIGH(ID_HI)) dut (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .mdc_i(mdc), .mdio_i(line),
      .mdio_o(mdio_o), .mdio_oe_o(mdio_oe), .tx_lpi_i(tx_lpi), .rx_lpi_i(rx_lpi),
      .tx_fault_i(tx_fault), .rx_fault_i(rx_fault), .rx_link_i(rx_link),
      .active_speed_i(spd), .sublayer_reset_o(rst_pulse),
      .sublayer_loopback_enable_o(lpbk), .low_power_request_o(low_power_request),
      .clock_stoppable_o(clk_stop), .extended_speed_field_o(espd),
      .tx_stacking_header_enable_o(tx_hdr), .rx_stacking_header_enable_o(rx_hdr),
      .tx_timestamp_code_enable_o(ts_en), .tx_long_message_select_o(len32));

   initial forever #12.5 core_clk_i = ~core_clk_i;

   always @(posedge core_clk_i) begin
      cycles++;
      if (rst_pulse === 1'b1) pulses++;
      if (mdio_oe === 1'b1) oe_cycles++;
      if (cycles == 80000) begin
         err_total++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic t_const();
      logic [15:0] a [12] = '{REG_CTRL1, REG_CTRL2, REG_ID_LO, REG_ID_HI, REG_SPEED,
         REG_PKG_LO, REG_PKG_HI, REG_STAT2, REG_PKGID_LO, REG_PKGID_HI, REG_LPI_CAP, 16'h0009};
      logic [15:0] e [12] = '{16'h2040, 16'h0003, ID_LO, ID_HI, 16'h00c1, 16'h009b,
         16'hc000, 16'hb008, 16'h0000, 16'h0000, 16'h0008, 16'h0000};
      `CHK("reset outs", 8'h00, {rst_pulse, lpbk, low_power_request, clk_stop, espd})
      `CHK("reset stacking", 4'h0, {rx_hdr, len32, ts_en, tx_hdr})
      for (int i = 0; i < 12; i++) begin
         sme.rd(a[i], v);
         `CHK("fixed word", e[i], v)
      end
      // Read with increment steps from the low to the high identifier word
      sme.frame(OP_ADDR, PORT, DEVAD_PCS, REG_ID_LO, v);
      sme.frame(OP_READ_INC, PORT, DEVAD_PCS, 16'h0000, v);
      sme.frame(2'h3, PORT, DEVAD_PCS, 16'h0000, w);
      `CHK("identifier", {ID_HI, ID_LO}, {w, v})
   endtask

   task automatic t_ctrl();
      int p;
      sme.rmw(REG_CTRL1, 16'h5c1c, 16'h2040);
      sme.rd(REG_CTRL1, v);
      `CHK("control one", 16'h7c5c, v)
      `CHK("control outs", 7'h77, {lpbk, low_power_request, clk_stop, espd})
      sme.rmw(REG_CTRL1, 16'h0000, 16'h4c00);
      sme.rd(REG_CTRL1, v);
      `CHK("control one", 16'h305c, v)
      `CHK("control outs", 7'h07, {lpbk, low_power_request, clk_stop, espd})
      p = pulses;
      sme.rmw(REG_CTRL1, 16'h8000, 16'h0000);
      sme.rd(REG_CTRL1, v);
      `CHK("reset pulses", 1, pulses - p)
      `CHK("control one", 16'h305c, v)
   endtask

   task automatic t_lat();
      sme.rd(REG_STAT1, v);
      `CHK("status one", 16'h0002, v)
      sme.rd(REG_STAT1, v);
      `CHK("status one", 16'h0006, v)
      tx_lpi = 1'b1;
      rx_fault = 1'b1;
      rx_link = 1'b0;
      repeat (3) @(negedge core_clk_i);
      tx_lpi = 1'b0;
      rx_fault = 1'b0;
      rx_link = 1'b1;
      sme.rd(REG_STAT1, v);
      `CHK("status one", 16'h0802, v)
      sme.rd(REG_STAT2, v);
      `CHK("status two", 16'hb408, v)
      sme.rd(REG_STAT1, v);
      `CHK("status one", 16'h0006, v)
      sme.rd(REG_STAT2, v);
      `CHK("status two", 16'hb008, v)
      tx_lpi = 1'b1;
      rx_lpi = 1'b1;
      tx_fault = 1'b1;
      repeat (3) @(negedge core_clk_i);
      sme.rd(REG_STAT1, v);
      `CHK("status one", 16'h0f86, v)
      sme.rd(REG_STAT2, v);
      `CHK("status two", 16'hb808, v)
      tx_lpi = 1'b0;
      rx_lpi = 1'b0;
      tx_fault = 1'b0;
      sme.rd(REG_STAT1, v);
      `CHK("status one", 16'h0c06, v)
      sme.rd(REG_STAT1, v);
      `CHK("status one", 16'h0006, v)
      rx_fault = 1'b1;
      sme.rd(REG_STAT1, v);
      `CHK("status one", 16'h0086, v)
      rx_fault = 1'b0;
      sme.rd(REG_STAT2, v);
      `CHK("status two", 16'hb408, v)
   endtask

   task automatic t_type();
      logic [1:0]  s [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
      logic [15:0] e [4] = '{16'h000b, 16'h000a, 16'h000a, 16'h0003};
      for (int i = 0; i < 4; i++) begin
         spd = s[i];
         sme.rd(REG_CTRL2, v);
         `CHK("sublayer type", e[i], v)
      end
   endtask

   task automatic t_stack();
      sme.wr(REG_STACK, 16'hffff);
      sme.rd(REG_STACK, v);
      `CHK("stacking word", 16'h0087, v)
      `CHK("stacking outs", 4'hf, {rx_hdr, len32, ts_en, tx_hdr})
      sme.wr(REG_STACK, 16'h0005);
      sme.rd(REG_STACK, v);
      `CHK("stacking word", 16'h0005, v)
      `CHK("stacking outs", 4'h5, {rx_hdr, len32, ts_en, tx_hdr})
   endtask

   task automatic t_refused();
      int o;
      sme.frame(OP_ADDR, PORT, DEVAD_PCS, REG_CTRL1, v);
      o = oe_cycles;
      sme.frame(OP_WRITE, PORT ^ 5'h01, DEVAD_PCS, 16'h4000, v);
      sme.frame(OP_WRITE, PORT, 5'h01, 16'h4000, v);
      sme.frame(2'h3, PORT ^ 5'h01, DEVAD_PCS, 16'h0000, v);
      `CHK("foreign drive", 0, oe_cycles - o)
      `CHK("loopback", 1'b0, lpbk)
      sme.wr(REG_SPEED, 16'hffff);
      sme.rd(REG_SPEED, v);
      `CHK("speed word", 16'h00c1, v)
   endtask

   initial begin
      repeat (12) @(negedge core_clk_i);
      rst_i = 1'b0;
      t_const();
      t_ctrl();
      t_lat();
      t_type();
      t_stack();
      t_refused();
      wrap_up();
   end
endmodule // tb
